// ==== bench/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host processor: single word transfers
module host_model
  import irq_clear_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output var  logic [31:0] haddr_o,
  output var  logic [1:0]  htrans_o,
  output var  logic        hwrite_o,
  output var  logic [31:0] hwdata_o
);
  initial begin
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // Waits on hready, never a fixed count, so slow slaves work too
  // acknowledge by writing ones
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    haddr_o <= a;
    hwrite_o <= w;
    htrans_o <= HTRANS_NS;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    htrans_o <= 2'h0;
    hwdata_o <= d;
    do @(posedge clk_i); while (hready_i !== 1'b1);
    q = hrdata_i;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irq_clear_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic [1:0]  htrans;
  logic        hwrite;
  logic        hrdy;
  logic        hresp;
  logic        irq;
  logic [7:0]  ev;
  int          n_mismatch;
  int          n_checks;
  int          cyc;
  int          bits[5] = '{BIT_ARXC, BIT_ATXC, BIT_ARXT, BIT_TERR, BIT_TDON};

  irq_clear_top u_irq_clear_top (.MCLK_I(mclk), .RST_N_I(rst_n),
    .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hrdy),
    .AERIAL_RX_COMPLETE_I(ev[5]), .AERIAL_TX_COMPLETE_I(ev[4]),
    .AERIAL_RX_TIMEOUT_I(ev[3]), .TUNER_LINK_ERROR_I(ev[1]),
    .TUNER_LINK_DONE_I(ev[0]), .HRDATA_O(hrdata), .HREADYOUT_O(hrdy),
    .HRESP_O(hresp), .INTERRUPT_REQUEST_PIN_O(irq));
  host_model u_host_model (.clk_i(mclk), .hready_i(hrdy),
    .hrdata_i(hrdata), .haddr_o(haddr), .htrans_o(htrans),
    .hwrite_o(hwrite), .hwdata_o(hwdata));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    u_host_model.xfer(1'b0, {22'h0, a}, 32'h0, q);
    chk(q, e, "read");
    chk({31'h0, hresp}, 32'h0, "hresp okay");
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    u_host_model.xfer(1'b1, {22'h0, a}, {24'h0, d}, q);
  endtask
  // Event pulse of one cycle; flags land, then request follows
  task automatic pulse(input logic [7:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 8'h00;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic irq_is(input logic e);
    repeat (3) @(posedge mclk);
    #1;
    chk({31'h0, irq}, {31'h0, e}, "irq");
  endtask

  task automatic t_reset;
    rd(ADDR_MASK, RD_ZERO);
    rd(ADDR_RAW, RD_ZERO);
    chk({31'h0, irq}, 32'h0, "irq rst");
    wr(ADDR_MASK, 8'hFF);
    rd(ADDR_MASK, 32'h3B);
    wr(10'h100, 8'hFF);
    rd(10'h100, RD_ZERO);
  endtask
  // Each source alone: set, clear, then set again after the pulse
  task automatic t_each;
    for (int i = 0; i < 5; i++) begin
      pulse(8'h01 << bits[i]);
      rd(ADDR_STAT, 32'h1 << bits[i]);
      chk({31'h0, irq}, 32'h1, "irq set");
      wr(ADDR_CLRW, 8'h01 << bits[i]);
      irq_is(1'b0);
      rd(ADDR_RAW, RD_ZERO);
      rd(ADDR_STAT, RD_ZERO);
      pulse(8'h01 << bits[i]);
      rd(ADDR_RAW, 32'h1 << bits[i]);
      wr(ADDR_CLRW, 8'h01 << bits[i]);
    end
  endtask
  task automatic t_partial;
    pulse(8'h3B);
    wr(ADDR_CLRW, 8'hC4);
    rd(ADDR_RAW, 32'h3B);
    wr(ADDR_CLRW, 8'h01);
    rd(ADDR_RAW, 32'h3A);
    irq_is(1'b1);
    wr(ADDR_CLRW, 8'h3A);
    irq_is(1'b0);
  endtask
  task automatic t_masked;
    wr(ADDR_MASK, 8'h00);
    pulse(8'h21);
    rd(ADDR_RAW, 32'h21);
    rd(ADDR_STAT, RD_ZERO);
    irq_is(1'b0);
    wr(ADDR_CLRW, 8'h21);
    rd(ADDR_RAW, RD_ZERO);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    ev = 8'h00;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_each();
    t_partial();
    t_masked();
    stop_test();
  end
endmodule
`default_nettype wire

// ==== hw/irq_clear_pkg.sv ====
package irq_clear_pkg;
  localparam int          REG_W     = 8;
  // Byte addresses; the clear register's printed offset is its word index,
  // so it is reached at four times that index
  localparam logic [9:0]  ADDR_RAW  = 10'h3F0;
  localparam logic [9:0]  ADDR_STAT = 10'h3F4;
  localparam logic [9:0]  ADDR_MASK = 10'h3F8;
  localparam logic [9:0]  ADDR_CLR  = 10'h0FF;
  localparam logic [9:0]  ADDR_CLRW = 10'h3FC;
  localparam logic [7:0]  SRC_USED  = 8'h3B;
  localparam logic [7:0]  RST_ZERO  = 8'h00;
  localparam int          BIT_ARXC  = 5;
  localparam int          BIT_ATXC  = 4;
  localparam int          BIT_ARXT  = 3;
  localparam int          BIT_TERR  = 1;
  localparam int          BIT_TDON  = 0;
  localparam logic [1:0]  HTRANS_NS = 2'h2;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [31:0] RD_ZERO   = 32'h00000000;
endpackage

// ==== hw/irq_clear_top.sv ====
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module irq_clear_top
  import irq_clear_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  input  wire logic        AERIAL_RX_COMPLETE_I,
  input  wire logic        AERIAL_TX_COMPLETE_I,
  input  wire logic        AERIAL_RX_TIMEOUT_I,
  input  wire logic        TUNER_LINK_ERROR_I,
  input  wire logic        TUNER_LINK_DONE_I,
  output var  logic [31:0] HRDATA_O,
  output var  logic        HREADYOUT_O,
  output var  logic        HRESP_O,
  output var  logic        INTERRUPT_REQUEST_PIN_O
);
  logic [REG_W-1:0] mask;
  logic [REG_W-1:0] clear_pulse;
  logic [REG_W-1:0] raw;
  logic [REG_W-1:0] stat;
  logic [REG_W-1:0] events;
  logic             wr_pend;
  logic             rd_pend;
  logic [9:0]       addr_q;
  logic             next_wr_pend;
  logic             next_rd_pend;
  logic             addr_ok;
  logic             take;
  logic [9:0]       word_addr;
  logic             wr_mask;
  logic             wr_clear;
  logic [REG_W-1:0] wdata;
  logic [31:0]      next_rdata;
  logic             next_irq;
  logic             sel_raw;
  logic             sel_stat;
  logic             sel_mask;

  // All checks below share the one clock and reset
  default clocking dcb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  // Address phase decode; slave is always ready
  assign take      = HSEL_I & HREADY_I & (HTRANS_I == HTRANS_NS);
  assign word_addr = {HADDR_I[9:2], 2'b00};
  assign addr_ok   = (HSIZE_I == HSIZE_WORD);
  assign next_wr_pend = take & HWRITE_I & addr_ok;
  assign next_rd_pend = take & ~HWRITE_I;
  assign wdata     = HWDATA_I[REG_W-1:0];
  assign wr_mask   = wr_pend & (addr_q == ADDR_MASK);
  assign wr_clear  = wr_pend & (addr_q == ADDR_CLRW);

  // Source event vector in documented bit positions
  // bit placement
  assign events = {2'b00, AERIAL_RX_COMPLETE_I, AERIAL_TX_COMPLETE_I,
                   AERIAL_RX_TIMEOUT_I, 1'b0, TUNER_LINK_ERROR_I,
                   TUNER_LINK_DONE_I};

  // Bus phase tracking
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      addr_q  <= 10'h000;
    end else begin
      wr_pend <= next_wr_pend;
      rd_pend <= next_rd_pend;
      addr_q  <= word_addr;
    end
  end

  // mask resets disabled; reserved bits kept zero
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      mask <= RST_ZERO;
    end else if (wr_mask) begin
      mask <= wdata & SRC_USED;
    end
  end

  // self-clearing pulse, lasts one cycle after the write
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clear_pulse <= RST_ZERO;
    end else if (wr_clear) begin
      clear_pulse <= wdata & SRC_USED;
    end else begin
      clear_pulse <= RST_ZERO;
    end
  end

  // One flag pair per implemented source
  genvar g;
  generate
    for (g = 0; g < REG_W; g++) begin : g_src
      if (SRC_USED[g]) begin : g_used
        // clear acts on raw and status together
        irq_src_bit u_bit (
          .clk_i    (MCLK_I),
          .rst_n_i  (RST_N_I),
          .event_i  (events[g]),
          .enable_i (mask[g]),
          .clear_i  (clear_pulse[g]),
          .raw_o    (raw[g]),
          .stat_o   (stat[g])
        );
      end else begin : g_rsv
        assign raw[g]  = 1'b0;
        assign stat[g] = 1'b0;
      end
    end
  endgenerate

  // Read select on the address phase so data stands in the data phase
  // Clear register reads zero since it is write only
  assign sel_raw    = (word_addr == ADDR_RAW);
  assign sel_stat   = (word_addr == ADDR_STAT);
  assign sel_mask   = (word_addr == ADDR_MASK);
  assign next_rdata =
    sel_raw  ? {24'h000000, raw}  :
    sel_stat ? {24'h000000, stat} :
    sel_mask ? {24'h000000, mask} : RD_ZERO;

  // request follows any enabled status bit
  assign next_irq = |(stat & mask);

  // Registered outputs; read data valid in data phase
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      HRDATA_O                <= RD_ZERO;
      HREADYOUT_O             <= 1'b1;
      HRESP_O                 <= 1'b0;
      INTERRUPT_REQUEST_PIN_O <= 1'b0;
    end else begin
      HRDATA_O                <= next_rd_pend ? next_rdata : RD_ZERO;
      HREADYOUT_O             <= 1'b1;
      HRESP_O                 <= 1'b0;
      INTERRUPT_REQUEST_PIN_O <= next_irq;
    end
  end

  a_irq_follows: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    1'b1 |=> (INTERRUPT_REQUEST_PIN_O == $past(|(stat & mask))))
    else $error("request pin not following status");
  a_clear_self_zero: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (clear_pulse != RST_ZERO)
      |=> (clear_pulse == RST_ZERO || $past(wr_clear)))
    else $error("clear pulse held");
  a_rsv_no_clear: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (clear_pulse & ~SRC_USED) == RST_ZERO)
    else $error("reserved clear bit pulsed");
  a_bit5_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (wr_clear && wdata[BIT_ARXC]) |=> clear_pulse[BIT_ARXC])
    else $error("bit 5 clear missed");
  a_bit4_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (wr_clear && wdata[BIT_ATXC]) |=> clear_pulse[BIT_ATXC])
    else $error("bit 4 clear missed");
  a_bit3_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (wr_clear && wdata[BIT_ARXT]) |=> clear_pulse[BIT_ARXT])
    else $error("bit 3 clear missed");
  a_bit1_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (wr_clear && wdata[BIT_TERR]) |=> clear_pulse[BIT_TERR])
    else $error("bit 1 clear missed");
  a_bit0_clears: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (wr_clear && wdata[BIT_TDON]) |=> clear_pulse[BIT_TDON])
    else $error("bit 0 clear missed");
  a_mask_gates: assert property (@(posedge MCLK_I) disable iff (!RST_N_I)
    (mask == RST_ZERO) |=> !INTERRUPT_REQUEST_PIN_O)
    else $error("request with all masked");

  a_irq_rise: assert property (((stat & mask) != RST_ZERO)
    |=> INTERRUPT_REQUEST_PIN_O)
    else $error("request pin missed status");

  a_irq_fall: assert property (((stat & mask) == RST_ZERO)
    |=> !INTERRUPT_REQUEST_PIN_O)
    else $error("request pin stuck high");

  a_raw_takes_event: assert property (1'b1
    |=> ((raw & $past(events)) == $past(events)))
    else $error("raw bit missed event");

  a_stat_needs_mask: assert property (1'b1
    |=> ((stat & ~$past(stat) & ~$past(mask)) == RST_ZERO))
    else $error("status set while masked");

  a_stat_takes_ev: assert property (1'b1
    |=> ((stat & $past(events & mask)) == $past(events & mask)))
    else $error("status missed enabled event");

  a_clear_raw_all: assert property (1'b1
    |=> ((raw & $past(clear_pulse & ~events)) == RST_ZERO))
    else $error("raw bit survived clear");

  a_clear_stat_all: assert property (1'b1
    |=> ((stat & $past(clear_pulse & ~events)) == RST_ZERO))
    else $error("status bit survived clear");

  a_raw_kept: assert property (1'b1
    |=> ((raw & $past(raw & ~clear_pulse)) == $past(raw & ~clear_pulse)))
    else $error("raw bit lost");

  a_stat_kept: assert property (1'b1
    |=> ((stat & $past(stat & ~clear_pulse)) == $past(stat & ~clear_pulse)))
    else $error("status bit lost");

  a_stat_in_raw: assert property ((stat & ~raw) == RST_ZERO)
    else $error("status set without raw");

  a_rsv_raw_zero: assert property ((raw & ~SRC_USED) == RST_ZERO)
    else $error("reserved raw bit set");

  a_rsv_stat_zero: assert property ((stat & ~SRC_USED) == RST_ZERO)
    else $error("reserved status bit set");

  a_rsv_mask_zero: assert property ((mask & ~SRC_USED) == RST_ZERO)
    else $error("reserved mask bit set");

  // no pulse without a clear write
  a_clear_idle_zero: assert property (!wr_clear
    |=> (clear_pulse == RST_ZERO))
    else $error("clear pulse without write");

  a_clear_from_data: assert property (wr_clear
    |=> (clear_pulse == $past(wdata & SRC_USED)))
    else $error("clear pulse differs from data");

  a_rsv_write_none: assert property ((wr_clear
    && ((wdata & SRC_USED) == RST_ZERO)) |=> (clear_pulse == RST_ZERO))
    else $error("reserved write pulsed");

  a_mask_write: assert property (wr_mask
    |=> (mask == $past(wdata & SRC_USED)))
    else $error("mask write lost");

  a_mask_holds: assert property (!wr_mask |=> $stable(mask))
    else $error("mask changed without write");

  a_rd_raw: assert property ((rd_pend && addr_q == ADDR_RAW)
    |-> (HRDATA_O == {24'h000000, $past(raw)}))
    else $error("raw read data wrong");

  a_rd_stat: assert property ((rd_pend && addr_q == ADDR_STAT)
    |-> (HRDATA_O == {24'h000000, $past(stat)}))
    else $error("status read data wrong");

  a_rd_mask: assert property ((rd_pend && addr_q == ADDR_MASK)
    |-> (HRDATA_O == {24'h000000, $past(mask)}))
    else $error("mask read data wrong");

  a_rd_clear_zero: assert property ((rd_pend && addr_q == ADDR_CLRW)
    |-> (HRDATA_O == RD_ZERO))
    else $error("clear register read nonzero");

  // bit 5 drops its raw flag
  a_arxc_raw_clr: assert property ((clear_pulse[BIT_ARXC]
    && !events[BIT_ARXC]) |=> !raw[BIT_ARXC])
    else $error("bit 5 raw not cleared");

  // bit 4 drops its raw flag
  a_atxc_raw_clr: assert property ((clear_pulse[BIT_ATXC]
    && !events[BIT_ATXC]) |=> !raw[BIT_ATXC])
    else $error("bit 4 raw not cleared");

  // bit 3 drops its raw flag
  a_arxt_raw_clr: assert property ((clear_pulse[BIT_ARXT]
    && !events[BIT_ARXT]) |=> !raw[BIT_ARXT])
    else $error("bit 3 raw not cleared");

  // bit 1 drops its raw flag
  a_terr_raw_clr: assert property ((clear_pulse[BIT_TERR]
    && !events[BIT_TERR]) |=> !raw[BIT_TERR])
    else $error("bit 1 raw not cleared");

  // bit 0 drops its raw flag
  a_tdon_raw_clr: assert property ((clear_pulse[BIT_TDON]
    && !events[BIT_TDON]) |=> !raw[BIT_TDON])
    else $error("bit 0 raw not cleared");
endmodule
`default_nettype wire

// ==== hw/irq_src_bit.sv ====
`timescale 1ns/1ps
`default_nettype none
// One interrupt source: raw and status flags with set-over-clear
module irq_src_bit (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic event_i,
  input  wire logic enable_i,
  input  wire logic clear_i,
  output var  logic raw_o,
  output var  logic stat_o
);
  logic next_raw;
  logic next_stat;
  // Set wins over clear so a coincident event is not lost
  // raw always, status only when enabled
  assign next_raw  = event_i | (raw_o & ~clear_i);
  assign next_stat = (event_i & enable_i) | (stat_o & ~clear_i);

  // Flag storage
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_o  <= 1'b0;
      stat_o <= 1'b0;
    end else begin
      raw_o  <= next_raw;
      stat_o <= next_stat;
    end
  end

  a_masked_no_stat: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (event_i && !enable_i && !stat_o) |=> (raw_o && !stat_o))
    else $error("masked event set status");
  a_clear_drops: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (clear_i && !event_i) |=> (!raw_o && !stat_o))
    else $error("clear did not drop flags");
  a_zero_keeps: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!clear_i && raw_o) |=> raw_o)
    else $error("raw bit lost without clear");
endmodule
`default_nettype wire
